// File: hdl/vicp_map.svh
// Register map, field positions, reset values and timing counts
`ifndef VICP_MAP_SVH
`define VICP_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VICP_OFS_INSEL 8'h00
`define VICP_OFS_FMT   8'h04
`define VICP_OFS_AGC   8'h08
`define VICP_OFS_PLLC  8'h0C
`define VICP_OFS_PLLF  8'h10
`define VICP_OFS_TGC   8'h14
`define VICP_OFS_STAT  8'h18
`define VICP_OFS_MASK  8'h1C
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VICP_INSEL_SVID  2
`define VICP_PLLC_PRE    8
`define VICP_PLLC_POST   9
`define VICP_ST_LOF      0
`define VICP_ST_COF      1
`define VICP_ST_UNLOCK   2
`define VICP_ST_LOCK     4
`define VICP_ST_ONPLL    5
// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define VICP_RST_AGC_DLY 8'h20
`define VICP_RST_TOPREF  8'h80
`define VICP_RST_PLL_INT 6'h00
`define VICP_RST_PLL_FRC 16'h0000
`define VICP_AGC_TARGET  8'h38
`define VICP_ADC_FULL    8'hFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VICP_CLK_NS      10
`define VICP_GAP_NS      40
`define VICP_GAP_CYC     ((`VICP_GAP_NS + `VICP_CLK_NS - 1) / `VICP_CLK_NS)
`define VICP_CLAMP_DLY_NS 500
`define VICP_CLAMP_LEN_NS 2000
`define VICP_CLAMP_DLY ((`VICP_CLAMP_DLY_NS + `VICP_CLK_NS - 1) / `VICP_CLK_NS)
`define VICP_CLAMP_LEN (`VICP_CLAMP_LEN_NS / `VICP_CLK_NS)
`endif

// File: hdl/vicp_pkg.sv
// Types shared by the video input clock and PLL control block
package vicp_pkg;
  typedef logic [7:0] vicp_addr_t;
  typedef enum logic [2:0] {
    VICP_FMT_NTSC_M = 3'h0,
    VICP_FMT_NTSC_J = 3'h1,
    VICP_FMT_PAL    = 3'h2,
    VICP_FMT_PAL_M  = 3'h3,
    VICP_FMT_PAL_N  = 3'h4,
    VICP_FMT_SECAM  = 3'h5
  } vicp_fmt_t;
  typedef enum logic [1:0] {
    VICP_CS_XTAL  = 2'h0,
    VICP_CS_TOPLL = 2'h1,
    VICP_CS_PLL   = 2'h2,
    VICP_CS_TOXTL = 2'h3
  } vicp_csw_st_t;
endpackage

// File: hdl/vicp_decim.sv
// Low-pass filter and 2:1 decimator for one video channel
`timescale 1ns/1ps
`include "vicp_map.svh"
module vicp_decim (
  input  wire logic       mclk_i,    // Reference clock
  input  wire logic       rst_n_i,   // Async reset, low
  input  wire logic [7:0] smp_i,     // 8x rate sample
  input  wire logic       smp_vld_i, // Sample valid
  output logic      [7:0] dec_o,     // 4x rate filtered sample
  output logic            dec_vld_o  // Output valid pulse
);
  logic [7:0] x1_q, x2_q;
  logic       ph_q;
  logic [9:0] sum;

  // Binomial taps, rounded
  assign sum = 10'(smp_i) + {1'b0, x1_q, 1'b0} + 10'(x2_q) + 10'h002;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x1_q <= 8'h00;
      x2_q <= 8'h00;
      ph_q <= 1'b0;
    end else if (smp_vld_i) begin
      x1_q <= smp_i;
      x2_q <= x1_q;
      ph_q <= ~ph_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_o     <= 8'h00;
      dec_vld_o <= 1'b0;
    end else begin
      dec_vld_o <= smp_vld_i && ph_q;
      if (smp_vld_i && ph_q)
        dec_o <= sum[9:2];
    end
  end

  AST_DECIM_HALF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dec_vld_o |=> !dec_vld_o)
    else $error("decimator output twice in a row");
endmodule // vicp_decim

// File: hdl/vicp_clksw.sv
// Break-before-make switch between crystal and PLL clock paths
`timescale 1ns/1ps
`include "vicp_map.svh"
module vicp_clksw
  import vicp_pkg::*;
(
  input  wire logic mclk_i,    // Reference clock
  input  wire logic rst_n_i,   // Async reset, low
  input  wire logic use_pll_i, // Request PLL source
  output logic      xtal_en_o, // Crystal path enable
  output logic      pll_en_o,  // PLL path enable
  output logic      on_pll_o   // Switch settled on PLL
);
  vicp_csw_st_t st_q;
  logic [3:0]   gap_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q  <= VICP_CS_XTAL;
      gap_q <= 4'h0;
    end else begin
      // Count loaded one short: enable edge adds the last dead cycle
      case (st_q)
        VICP_CS_XTAL: if (use_pll_i) begin
          st_q  <= VICP_CS_TOPLL;
          gap_q <= 4'(`VICP_GAP_CYC - 1);
        end
        VICP_CS_TOPLL: if (gap_q <= 4'h1) st_q <= VICP_CS_PLL;
          else gap_q <= gap_q - 4'h1;
        VICP_CS_PLL: if (!use_pll_i) begin
          st_q  <= VICP_CS_TOXTL;
          gap_q <= 4'(`VICP_GAP_CYC - 1);
        end
        VICP_CS_TOXTL: if (gap_q <= 4'h1) st_q <= VICP_CS_XTAL;
          else gap_q <= gap_q - 4'h1;
        default: st_q <= VICP_CS_XTAL;
      endcase
    end
  end

  // Both paths off during the gap
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xtal_en_o <= 1'b1;
      pll_en_o  <= 1'b0;
      on_pll_o  <= 1'b0;
    end else begin
      xtal_en_o <= (st_q == VICP_CS_XTAL) && !use_pll_i;
      pll_en_o  <= (st_q == VICP_CS_PLL) && use_pll_i;
      on_pll_o  <= (st_q == VICP_CS_PLL);
    end
  end

  AST_CLKSW_BBM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(xtal_en_o) |-> !pll_en_o [*3])
    else $error("PLL path enabled without dead gap");
  COV_TO_PLL: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(pll_en_o));
endmodule // vicp_clksw

// File: hdl/vicp_top.sv
// Video input selection, gain loop, clamp, decimation and PLL control
// ----------------------------------------------------------------
// Functional notes
// - One of four analog inputs selected
// - Full-scale luma or chroma sets overflow flag
// - Reset loads every register default
// - Reset selects NTSC-M format
// - Gain loop drives back porch luma to 0x38
// - Clamp strobe within sync tip
// - Pixel clock from pre, multiplier, post dividers
// - Pre-divider halves, post-divider divides by six
// - Zero integer multiplier powers PLL down
// - Unlock flag reports out-of-lock condition
// - Sample at 8x, filter, decimate to 4x
// - Filter limits video bandwidth
// ----------------------------------------------------------------
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "vicp_map.svh"
module vicp_top
  import vicp_pkg::*;
(
  input  wire logic        mclk_i,       // Reference clock
  input  wire logic        rst_n_i,      // Async reset, low
  input  vicp_pkg::vicp_addr_t reg_addr_i, // Register address
  input  wire logic [31:0] reg_wdata_i,  // Write data
  input  wire logic        reg_we_i,     // Write strobe
  input  wire logic        reg_re_i,     // Read strobe
  output logic      [31:0] reg_rdata_o,  // Read data, next cycle
  input  wire logic        hsync_i,      // Sync tip active
  input  wire logic [7:0]  luma_smp_i,   // Luma A/D code
  input  wire logic [7:0]  chroma_smp_i, // Chroma A/D code
  input  wire logic        smp_vld_i,    // A/D sample valid
  input  wire logic        pll_locked_i, // Raw PLL lock, async
  output logic      [3:0]  mux_en_o,     // Input mux one-hot
  output logic             svideo_mode_o, // Input 3 is S-Video luma
  output vicp_pkg::vicp_fmt_t video_format_o, // Video standard
  output logic      [7:0]  top_ref_o,    // Converter top reference
  output logic             clamp_o,      // Clamp strobe
  output logic      [7:0]  chroma_clamp_lvl_o, // Chroma clamp level
  output logic             pll_pre_div2_o, // Reference / 2
  output logic             pll_post_div6_o, // Output / 6
  output logic      [5:0]  pll_int_o,    // Integer multiplier
  output logic      [15:0] pll_frac_o,   // Fractional multiplier
  output logic             pll_pwrdn_o,  // PLL shut down
  output logic             xtal_clk_en_o, // Crystal clock path
  output logic             pll_clk_en_o, // PLL clock path
  output logic      [7:0]  luma_dec_o,   // Decimated luma
  output logic      [7:0]  chroma_dec_o, // Decimated chroma
  output logic             dec_vld_o,    // Decimated valid
  output logic             irq_o         // Interrupt, level
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [1:0]  in_sel_q;
  logic        svid_q;
  vicp_fmt_t   fmt_q;
  logic [7:0]  agc_dly_q;
  logic        pre_q, post_q;
  logic [5:0]  pll_int_q;
  logic [15:0] pll_frac_q;
  logic        tg_pll_q;
  logic [2:0]  st_q, mask_q, st_set;
  logic        lock_q, on_pll;
  logic [7:0]  top_ref_q;
  logic        wr_insel, wr_fmt, wr_agc, wr_pllc, wr_pllf;
  logic        wr_tgc, wr_stat, wr_mask;

  assign wr_insel = reg_we_i && reg_addr_i == `VICP_OFS_INSEL;
  assign wr_fmt   = reg_we_i && reg_addr_i == `VICP_OFS_FMT;
  assign wr_agc   = reg_we_i && reg_addr_i == `VICP_OFS_AGC;
  assign wr_pllc  = reg_we_i && reg_addr_i == `VICP_OFS_PLLC;
  assign wr_pllf  = reg_we_i && reg_addr_i == `VICP_OFS_PLLF;
  assign wr_tgc   = reg_we_i && reg_addr_i == `VICP_OFS_TGC;
  assign wr_stat  = reg_we_i && reg_addr_i == `VICP_OFS_STAT;
  assign wr_mask  = reg_we_i && reg_addr_i == `VICP_OFS_MASK;

  // Input select
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_sel_q <= 2'h0;
      svid_q   <= 1'b0;
    end else if (wr_insel) begin
      in_sel_q <= reg_wdata_i[1:0];
      svid_q   <= reg_wdata_i[`VICP_INSEL_SVID];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fmt_q <= VICP_FMT_NTSC_M;
    end else if (wr_fmt) begin
      fmt_q <= vicp_fmt_t'(reg_wdata_i[2:0]);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      agc_dly_q <= `VICP_RST_AGC_DLY;
    end else if (wr_agc) begin
      agc_dly_q <= reg_wdata_i[7:0];
    end
  end

  // PLL divider and multiplier settings
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q      <= 1'b0;
      post_q     <= 1'b0;
      pll_int_q  <= `VICP_RST_PLL_INT;
      pll_frac_q <= `VICP_RST_PLL_FRC;
    end else begin
      if (wr_pllc) begin
        pre_q     <= reg_wdata_i[`VICP_PLLC_PRE];
        post_q    <= reg_wdata_i[`VICP_PLLC_POST];
        pll_int_q <= reg_wdata_i[5:0];
      end
      if (wr_pllf)
        pll_frac_q <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tg_pll_q <= 1'b0;
    end else if (wr_tgc) begin
      tg_pll_q <= reg_wdata_i[0];
    end
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= 3'h0;
    end else begin
      st_q <= (st_q & ~(wr_stat ? reg_wdata_i[2:0] : 3'h0)) | st_set;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= 3'h0;
    end else if (wr_mask) begin
      mask_q <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `VICP_OFS_INSEL: reg_rdata_o <= {29'h0, svid_q, in_sel_q};
        `VICP_OFS_FMT:   reg_rdata_o <= {29'h0, fmt_q};
        `VICP_OFS_AGC:   reg_rdata_o <= {16'h0, top_ref_q, agc_dly_q};
        `VICP_OFS_PLLC:  reg_rdata_o <= {22'h0, post_q, pre_q, 2'h0,
                                         pll_int_q};
        `VICP_OFS_PLLF:  reg_rdata_o <= {16'h0, pll_frac_q};
        `VICP_OFS_TGC:   reg_rdata_o <= {31'h0, tg_pll_q};
        `VICP_OFS_STAT:  reg_rdata_o <= {26'h0, on_pll,
                                         lock_q && !pll_pwrdn_o, 1'b0,
                                         st_q};
        `VICP_OFS_MASK:  reg_rdata_o <= {29'h0, mask_q};
        default:         reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign irq_o = |(st_q & mask_q);

  // ----------------------------------------------------------------
  // Input mux and PLL outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_en_o        <= 4'h1;
      svideo_mode_o   <= 1'b0;
      video_format_o  <= VICP_FMT_NTSC_M;
    end else begin
      mux_en_o        <= 4'(4'h1 << in_sel_q);
      svideo_mode_o   <= svid_q;
      video_format_o  <= fmt_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_pre_div2_o  <= 1'b0;
      pll_post_div6_o <= 1'b0;
      pll_int_o       <= `VICP_RST_PLL_INT;
      pll_frac_o      <= `VICP_RST_PLL_FRC;
      pll_pwrdn_o     <= 1'b1;
    end else begin
      pll_pre_div2_o  <= pre_q;
      pll_post_div6_o <= post_q;
      pll_int_o       <= pll_int_q;
      pll_frac_o      <= pll_frac_q;
      pll_pwrdn_o     <= (pll_int_q == 6'h00);
    end
  end

  // ----------------------------------------------------------------
  // Lock synchroniser and events
  // ----------------------------------------------------------------
  logic lk1_q, lk2_q, lk3_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk1_q  <= 1'b0;
      lk2_q  <= 1'b0;
      lk3_q  <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      lk1_q <= pll_locked_i;
      lk2_q <= lk1_q;
      lk3_q <= lk2_q;
      if (lk2_q == lk3_q)
        lock_q <= lk3_q;
    end
  end

  always_comb begin
    st_set = 3'h0;
    st_set[`VICP_ST_LOF] = smp_vld_i && luma_smp_i == `VICP_ADC_FULL;
    st_set[`VICP_ST_COF] = smp_vld_i && chroma_smp_i == `VICP_ADC_FULL;
    st_set[`VICP_ST_UNLOCK] = lock_q && !lk3_q && !lk2_q;
  end

  // ----------------------------------------------------------------
  // Gain loop and clamp
  // ----------------------------------------------------------------
  logic       hs_q, bp_run_q, agc_take;
  logic [7:0] bp_cnt_q, sy_cnt_q;

  assign agc_take = bp_run_q && smp_vld_i && bp_cnt_q == agc_dly_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_q     <= 1'b0;
      bp_run_q <= 1'b0;
      bp_cnt_q <= 8'h00;
      sy_cnt_q <= 8'h00;
    end else begin
      hs_q <= hsync_i;
      if (hs_q && !hsync_i) begin
        bp_run_q <= 1'b1;
        bp_cnt_q <= 8'h00;
      end else if (agc_take || hsync_i) begin
        bp_run_q <= 1'b0;
      end else if (bp_run_q && smp_vld_i && bp_cnt_q != 8'hFF) begin
        bp_cnt_q <= bp_cnt_q + 8'h01;
      end
      if (!hsync_i)
        sy_cnt_q <= 8'h00;
      else if (sy_cnt_q != 8'hFF)
        sy_cnt_q <= sy_cnt_q + 8'h01;
    end
  end

  // Lower reference raises the code
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      top_ref_q <= `VICP_RST_TOPREF;
    end else if (agc_take) begin
      if (luma_smp_i > `VICP_AGC_TARGET && top_ref_q != 8'hFF)
        top_ref_q <= top_ref_q + 8'h01;
      else if (luma_smp_i < `VICP_AGC_TARGET && top_ref_q != 8'h00)
        top_ref_q <= top_ref_q - 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clamp_o            <= 1'b0;
      top_ref_o          <= `VICP_RST_TOPREF;
      chroma_clamp_lvl_o <= 8'h40;
    end else begin
      clamp_o <= hsync_i && sy_cnt_q >= 8'(`VICP_CLAMP_DLY) &&
                 sy_cnt_q < 8'(`VICP_CLAMP_DLY + `VICP_CLAMP_LEN);
      top_ref_o          <= top_ref_q;
      chroma_clamp_lvl_o <= {1'b0, top_ref_q[7:1]};
    end
  end

  // ----------------------------------------------------------------
  // Decimation and clock switch
  // ----------------------------------------------------------------
  logic [7:0] ch_smp [2];
  logic [7:0] ch_dec [2];
  logic [1:0] ch_vld;

  assign ch_smp[0]    = luma_smp_i;
  assign ch_smp[1]    = chroma_smp_i;
  assign luma_dec_o   = ch_dec[0];
  assign chroma_dec_o = ch_dec[1];
  assign dec_vld_o    = ch_vld[0];

  for (genvar gi = 0; gi < 2; gi++) begin : g_ch
    vicp_decim u_decim (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .smp_i     (ch_smp[gi]),
      .smp_vld_i (smp_vld_i),
      .dec_o     (ch_dec[gi]),
      .dec_vld_o (ch_vld[gi])
    );
  end

  vicp_clksw u_clksw (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .use_pll_i (tg_pll_q),
    .xtal_en_o (xtal_clk_en_o),
    .pll_en_o  (pll_clk_en_o),
    .on_pll_o  (on_pll)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic up_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_q <= 1'b0;
    else up_q <= 1'b1;
  end

  AST_MUX_SEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_insel |=> ##1 mux_en_o == 4'(4'h1 << $past(reg_wdata_i[1:0], 2)))
    else $error("mux does not follow selection");

  AST_LOF_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    smp_vld_i && luma_smp_i == 8'hFF |=> st_q[0])
    else $error("luma overflow not flagged");

  AST_RST_DFLT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !up_q |-> fmt_q == VICP_FMT_NTSC_M && top_ref_q == 8'h80 &&
              pll_int_q == 6'h00 && st_q == 3'h0)
    else $error("register default wrong after reset");

  AST_FMT_NTSC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !up_q |=> video_format_o == VICP_FMT_NTSC_M)
    else $error("format not NTSC-M after reset");

  AST_AGC_DN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    agc_take && luma_smp_i < 8'h38 && top_ref_q != 8'h00
    |=> top_ref_q == $past(top_ref_q) - 8'h01)
    else $error("gain loop did not lower reference");

  AST_CLAMP_TIP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clamp_o |-> $past(hsync_i))
    else $error("clamp outside sync tip");

  AST_PLL_DIV: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_pllc |=> ##1 pll_pre_div2_o == $past(reg_wdata_i[8], 2) &&
                    pll_post_div6_o == $past(reg_wdata_i[9], 2))
    else $error("divider selects not applied");

  AST_PLL_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_pllc && reg_wdata_i[5:0] == 6'h00 |=> ##1 pll_pwrdn_o)
    else $error("PLL not shut down on zero");

  AST_LOCK_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    reg_re_i && reg_addr_i == 8'h18 && pll_pwrdn_o |=> !reg_rdata_o[4])
    else $error("lock shown while PLL is off");

  COV_AGC: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    agc_take);
  COV_UNLOCK: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_set[2]);
  COV_IRQ: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(irq_o));
endmodule // vicp_top

// File: bench/vicp_pll_model.sv
// Behavioural PLL lock source facing the clock control block
`timescale 1ns/1ps
module vicp_pll_model #(
  parameter int LOCK_CYC = 50 // Cycles to lock, shortened
) (
  input  wire logic mclk_i,   // Reference clock
  input  wire logic pwrdn_i,  // PLL shut down
  input  wire logic upset_i,  // Force loss of lock
  output logic      locked_o  // Raw lock, async to block
);
  int cnt_q = 0;
  // Lock only after a settling time while powered
  always_ff @(posedge mclk_i) begin
    if (pwrdn_i || upset_i) begin
      cnt_q <= 0;
    end else if (cnt_q < LOCK_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign locked_o = (cnt_q == LOCK_CYC);
endmodule // vicp_pll_model

// File: bench/vicp_top_tb_top.sv
// Self-checking bench for the video input clock and PLL control block
`timescale 1ns/1ps
`include "vicp_map.svh"
module vicp_top_tb_top;
  import vicp_pkg::*;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0;
  vicp_addr_t  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        we = 1'b0, re = 1'b0, hsync = 1'b0, vld = 1'b0;
  logic        upset = 1'b0, locked, svid, clamp, pre, post, pwrdn;
  logic        xen, pen, dvld, irq;
  logic [7:0]  luma = 8'h10, chroma = 8'h10, tref, clvl, ldec, cdec;
  logic [3:0]  mux;
  logic [5:0]  pint;
  logic [15:0] pfrac;
  vicp_fmt_t   fmt;
  int          miscompares = 0, n_tests = 0, cycles = 0, npulse = 0;

  always #5 mclk_i = ~mclk_i;

  vicp_top vicp_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .hsync_i(hsync), .luma_smp_i(luma),
    .chroma_smp_i(chroma), .smp_vld_i(vld), .pll_locked_i(locked),
    .mux_en_o(mux), .svideo_mode_o(svid), .video_format_o(fmt),
    .top_ref_o(tref), .clamp_o(clamp), .chroma_clamp_lvl_o(clvl),
    .pll_pre_div2_o(pre), .pll_post_div6_o(post), .pll_int_o(pint),
    .pll_frac_o(pfrac), .pll_pwrdn_o(pwrdn), .xtal_clk_en_o(xen),
    .pll_clk_en_o(pen), .luma_dec_o(ldec), .chroma_dec_o(cdec),
    .dec_vld_o(dvld), .irq_o(irq));
  vicp_pll_model vicp_pll_model_i (.mclk_i(mclk_i), .pwrdn_i(pwrdn),
    .upset_i(upset), .locked_o(locked));

  always @(negedge mclk_i) npulse += dvld;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input vicp_addr_t a, input logic [31:0] v);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge mclk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input vicp_addr_t a);
    @(posedge mclk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge mclk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("fmt", 32'(fmt), 32'(VICP_FMT_NTSC_M));
    chk("pins", 32'({mux, pwrdn, xen, pen}), 32'h0E);
    wr(`VICP_OFS_FMT, 32'(VICP_FMT_PAL));
    cyc(1);
    chk("fmtw", 32'(fmt), 32'(VICP_FMT_PAL));
    rd(`VICP_OFS_AGC);
    chk("agc", d, {16'h0, `VICP_RST_TOPREF, `VICP_RST_AGC_DLY});
    rd(8'h40);
    chk("unmapped", d, 32'h0);
  endtask
  task automatic t_insel();
    for (int i = 0; i < 4; i++) begin
      wr(`VICP_OFS_INSEL, 32'(i) | ((i == 3) ? 32'h4 : 32'h0));
      cyc(1);
      chk("mux", 32'({mux, svid}), 32'({4'h1 << i, i == 3}));
    end
  endtask
  task automatic t_ovf();
    wr(`VICP_OFS_MASK, 32'h7);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      luma   <= (k == 0) ? `VICP_ADC_FULL : 8'h10;
      chroma <= (k == 1) ? `VICP_ADC_FULL : 8'h10;
      vld    <= 1'b1;
      @(posedge mclk_i);
      vld <= 1'b0;
      rd(`VICP_OFS_STAT);
      chk("stat", d, 32'h1 << k);
      chk("irq", 32'(irq), 32'h1);
      wr(`VICP_OFS_MASK, 32'h0);
      cyc(0);
      chk("masked", 32'(irq), 32'h0);
      wr(`VICP_OFS_MASK, 32'h7);
      wr(`VICP_OFS_STAT, 32'h1 << k);
      rd(`VICP_OFS_STAT);
      chk("w1c", d | 32'(irq), 32'h0);
    end
  endtask
  task automatic t_pll();
    int   g;
    logic both;
    g    = 0;
    both = 1'b0;
    d    = 32'h0;
    wr(`VICP_OFS_PLLC, 32'h10E);
    wr(`VICP_OFS_PLLF, 32'hDCF9);
    cyc(1);
    chk("div", 32'({pre, post, pwrdn, pint}), 32'({3'h4, 6'h0E}));
    chk("frac", 32'(pfrac), 32'hDCF9);
    for (int n = 0; n < 100 && !d[4]; n++) rd(`VICP_OFS_STAT);
    chk("lock", 32'(d[4]), 32'h1);
    wr(`VICP_OFS_TGC, 32'h1);
    repeat (12) begin
      cyc(1);
      g += (!xen && !pen);
      both |= xen && pen;
    end
    chk("gap", g, `VICP_GAP_CYC);
    chk("sw", 32'({both, xen, pen}), 32'h1);
    rd(`VICP_OFS_STAT);
    chk("onpll", 32'(d[5]), 32'h1);
    @(posedge mclk_i);
    upset <= 1'b1;
    cyc(8);
    rd(`VICP_OFS_STAT);
    chk("lost", 32'({d[2], d[4], irq}), 32'h5);
    upset <= 1'b0;
    wr(`VICP_OFS_TGC, 32'h0);
    wr(`VICP_OFS_PLLC, 32'h200);
    cyc(1);
    chk("pwrdn", 32'({pwrdn, post}), 32'h3);
  endtask
  task automatic t_clamp();
    @(posedge mclk_i);
    hsync <= 1'b1;
    cyc(20);
    chk("clamp0", 32'(clamp), 32'h0);
    cyc(80);
    chk("clamp1", 32'({clamp, clvl}),
        32'({1'b1, `VICP_RST_TOPREF >> 1}));
    cyc(180);
    chk("clamp2", 32'(clamp), 32'h0);
    @(posedge mclk_i);
    hsync <= 1'b0;
  endtask
  task automatic t_feed();
    wr(`VICP_OFS_AGC, 32'h2);
    npulse = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk_i);
      luma   <= 8'h50;
      chroma <= 8'h30;
      vld    <= (i < 16);
    end
    chk("dec", 32'({ldec, cdec}), 32'h5030);
    chk("pulses", npulse, 8);
    rd(`VICP_OFS_AGC);
    chk("agc", d, {16'h0, `VICP_RST_TOPREF + 8'h01, 8'h02});
    chk("tref", 32'(tref), 32'(`VICP_RST_TOPREF + 8'h01));
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    t_reset();
    t_insel();
    t_ovf();
    t_pll();
    t_clamp();
    t_feed();
    print_verdict();
  end
endmodule // vicp_top_tb_top
